// ==== include/conv_unit_map.svh ====
/*
 * Register offsets, field positions, reset values and selector limits for the
 * digit decode / encode / character code unit.
 * Assumes a 4-bit register index and 16-bit data words.
 */
`ifndef CONV_UNIT_MAP_SVH
`define CONV_UNIT_MAP_SVH

// --------------------------------------------------------------------
// Register index map
// --------------------------------------------------------------------
`define CV_REG_CMD      4'h0
`define CV_REG_SEL      4'h1
`define CV_REG_ROOM     4'h2
`define CV_REG_PTR      4'h3
`define CV_REG_SRC0     4'h4
`define CV_REG_DST0     4'h8
`define CV_REG_STATUS   4'hC

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define CV_CMD_OP_LO    0
`define CV_CMD_PTR_USE  2
`define CV_ST_FAULT     0
`define CV_ST_RAN       1
`define CV_ST_SKIPPED   2
`define CV_SEL_FIRST_LO 0
`define CV_SEL_CNT_LO   4
`define CV_SEL_TOP_LO   12
`define CV_SEL_HALF     8
`define CV_SEL_PAR_LO   9
`define CV_SEL_RSV      11

// --------------------------------------------------------------------
// Reset values and limits
// --------------------------------------------------------------------
`define CV_RST_WORD     16'h0000
`define CV_RST_ROOM     16'h0004
`define CV_DM_WORDS     1000
`define CV_DIGIT_MAX    4'h3
`define CV_DEC_LIMIT    4'h9
`define CV_ASCII_DIGIT  8'h30
`define CV_ASCII_ALPHA  8'h37

`endif

// ==== include/conv_pkg.sv ====
/*
 * Types shared by the conversion unit.
 * Assumes nothing of its surroundings.
 */
package conv_pkg;

    typedef enum logic [1:0] {
        OP_DECODE,
        OP_ENCODE,
        OP_ASCII,
        OP_SPARE
    } op_t;

    typedef enum logic [1:0] {
        PAR_NONE,
        PAR_EVEN,
        PAR_ODD,
        PAR_BAD
    } parity_t;

endpackage

// ==== rtl/conv_unit.sv ====
/*
 * Digit-to-bit decoder, highest-bit encoder and digit-to-character converter
 * for an instruction executor, with operand and result registers.
 * Assumes one clock, inputs synchronous to it, and a master that writes the
 * operands before writing the command register that launches an operation.
 */
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "conv_unit_map.svh"

module conv_unit
    import conv_pkg::*;
#(
    parameter int DM_WORDS = `CV_DM_WORDS
) (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        EXEC_COND,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [15:0] RD_DATA,
    output logic             DONE,
    output logic             FAULT
);

    // --------------------------------------------------------------------
    // Helper functions
    // --------------------------------------------------------------------
    function automatic logic [3:0] digit_of(input logic [15:0] w, input logic [1:0] idx);
        digit_of = w[{idx, 2'h0} +: 4];
    endfunction

    // Four-word banks are told apart by the upper two index bits
    function automatic logic in_bank(input logic [3:0] a, input logic [3:0] base);
        in_bank = (a[3:2] == base[3:2]);
    endfunction

    // Positions wrap modulo four, which gives every turn-around rule for free
    function automatic logic [1:0] wrap_pos(input logic [1:0] start, input int step);
        wrap_pos = start + 2'(step);
    endfunction

    function automatic logic [3:0] top_bit(input logic [15:0] w);
        logic [3:0] r;
        r = 4'h0;
        for (int b = 0; b < 16; b++) begin
            if (w[b]) begin
                r = 4'(b);
            end
        end
        top_bit = r;
    endfunction

    function automatic logic bcd_ok(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int n = 0; n < 4; n++) begin
            if (w[n*4 +: 4] > `CV_DEC_LIMIT) begin
                ok = 1'b0;
            end
        end
        bcd_ok = ok;
    endfunction

    function automatic logic [15:0] bcd_value(input logic [15:0] w);
        bcd_value = 16'(w[15:12]) * 16'h03E8 + 16'(w[11:8]) * 16'h0064
                  + 16'(w[7:4]) * 16'h000A + 16'(w[3:0]);
    endfunction

    function automatic logic [7:0] to_char(input logic [3:0] d, input parity_t par);
        logic [7:0] c;
        logic       odd_ones;
        c        = (d > `CV_DEC_LIMIT) ? `CV_ASCII_ALPHA + 8'(d) : `CV_ASCII_DIGIT + 8'(d);
        odd_ones = ^c[6:0];
        case (par)
            PAR_EVEN: c[7] = odd_ones;
            PAR_ODD:  c[7] = ~odd_ones;
            default:  c[7] = 1'b0;
        endcase
        to_char = c;
    endfunction

    // --------------------------------------------------------------------
    // Operand and result registers
    // --------------------------------------------------------------------
    op_t         op;
    logic        ptr_use;
    logic [15:0] sel;
    logic [15:0] room;
    logic [15:0] ptr;
    logic [15:0] src [4];
    logic [15:0] dst [4];
    logic        ran;
    logic        skipped;

    // --------------------------------------------------------------------
    // Command launch
    // --------------------------------------------------------------------
    logic        wr_cmd;
    logic        launch;
    logic        execute;

    assign wr_cmd  = WR_STB && (ADDR == `CV_REG_CMD);
    assign launch  = wr_cmd;
    assign execute = launch && EXEC_COND;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            op      <= OP_DECODE;
            ptr_use <= 1'b0;
        end else if (wr_cmd) begin
            op      <= op_t'(WR_DATA[`CV_CMD_OP_LO +: 2]);
            ptr_use <= WR_DATA[`CV_CMD_PTR_USE];
        end
    end

    // The command write launches with the fields it carries, not the
    // previously stored ones, so one write is one execution.
    op_t  cur_op;
    logic cur_ptr_use;

    assign cur_op      = op_t'(WR_DATA[`CV_CMD_OP_LO +: 2]);
    assign cur_ptr_use = WR_DATA[`CV_CMD_PTR_USE];

    // --------------------------------------------------------------------
    // Operand registers
    // --------------------------------------------------------------------

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel  <= `CV_RST_WORD;
            room <= `CV_RST_ROOM;
            ptr  <= `CV_RST_WORD;
        end else if (WR_STB) begin
            case (ADDR)
                `CV_REG_SEL:  sel  <= WR_DATA;
                `CV_REG_ROOM: room <= WR_DATA;
                `CV_REG_PTR:  ptr  <= WR_DATA;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int k = 0; k < 4; k++) begin
                src[k] <= `CV_RST_WORD;
            end
        end else if (WR_STB && in_bank(ADDR, `CV_REG_SRC0)) begin
            src[ADDR[1:0]] <= WR_DATA;
        end
    end

    // --------------------------------------------------------------------
    // Selector decode
    // --------------------------------------------------------------------
    logic [1:0] first;
    logic [2:0] cnt;
    logic       half;
    parity_t    par;
    logic       sel_bad;
    logic       asc_sel_bad;

    assign first = sel[`CV_SEL_FIRST_LO +: 2];
    assign cnt   = {1'b0, sel[`CV_SEL_CNT_LO +: 2]} + 3'h1;
    assign half  = sel[`CV_SEL_HALF];
    assign par   = parity_t'(sel[`CV_SEL_PAR_LO +: 2]);

    assign sel_bad = (sel[`CV_SEL_FIRST_LO +: 4] > `CV_DIGIT_MAX)
                   || (sel[`CV_SEL_CNT_LO +: 4] > `CV_DIGIT_MAX);
    assign asc_sel_bad = sel_bad || (par == PAR_BAD) || sel[`CV_SEL_RSV]
                       || (sel[`CV_SEL_TOP_LO +: 4] != 4'h0);

    // --------------------------------------------------------------------
    // Fault detection
    // --------------------------------------------------------------------
    logic [2:0] need;
    logic       room_bad;
    logic       ptr_bad;
    logic       zero_src;
    logic       next_fault;

    // Destination words touched by the character converter depend on the
    // starting half: a high start spills one more word when the count is even.
    always_comb begin
        case (cur_op)
            OP_ASCII: need = 3'(({2'h0, half} + cnt + 3'h1) >> 1);
            default:  need = cnt;
        endcase
    end

    assign room_bad = 16'(need) > room;
    // Only the pointer's form and range are checked; the indirect access lies outside
    assign ptr_bad  = cur_ptr_use
                    && (!bcd_ok(ptr) || (bcd_value(ptr) >= 16'(DM_WORDS)));

    always_comb begin
        zero_src = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if ((3'(i) < cnt) && (src[i] == 16'h0000)) begin
                zero_src = 1'b1;
            end
        end
    end

    always_comb begin
        case (cur_op)
            OP_DECODE: next_fault = sel_bad || room_bad || ptr_bad;
            OP_ENCODE: next_fault = sel_bad || room_bad || zero_src || ptr_bad;
            OP_ASCII:  next_fault = asc_sel_bad || room_bad || ptr_bad;
            default:   next_fault = 1'b1;
        endcase
    end

    // --------------------------------------------------------------------
    // Result datapath
    // --------------------------------------------------------------------
    logic [15:0] next_dst [4];
    logic [1:0]  pos;
    logic [2:0]  bpos;

    always_comb begin
        pos  = 2'b00;
        bpos = 3'b000;
        for (int k = 0; k < 4; k++) begin
            next_dst[k] = dst[k];
        end
        case (cur_op)
            OP_DECODE: begin
                for (int i = 0; i < 4; i++) begin
                    if (3'(i) < cnt) begin
                        pos = wrap_pos(first, i);
                        // Whole word rewritten, all other bits clear
                        next_dst[i] = 16'h0001 << digit_of(src[0], pos);
                    end
                end
            end
            OP_ENCODE: begin
                for (int i = 0; i < 4; i++) begin
                    if (3'(i) < cnt) begin
                        pos = wrap_pos(first, i);
                        next_dst[0][{pos, 2'b00} +: 4] = top_bit(src[i]);
                    end
                end
            end
            OP_ASCII: begin
                for (int i = 0; i < 4; i++) begin
                    if (3'(i) < cnt) begin
                        pos  = wrap_pos(first, i);
                        bpos = {2'b00, half} + 3'(i);
                        next_dst[bpos[2:1]][{bpos[0], 3'b000} +: 8] =
                            to_char(digit_of(src[0], pos), par);
                    end
                end
            end
            default: ;
        endcase
    end

    // --------------------------------------------------------------------
    // Result registers
    // --------------------------------------------------------------------
    // Software may preload destinations; the encoder and converter keep
    // the digits and bytes they do not reach.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int k = 0; k < 4; k++) begin
                dst[k] <= `CV_RST_WORD;
            end
        end else if (execute && !next_fault) begin
            for (int k = 0; k < 4; k++) begin
                dst[k] <= next_dst[k];
            end
        end else if (WR_STB && in_bank(ADDR, `CV_REG_DST0)) begin
            dst[ADDR[1:0]] <= WR_DATA;
        end
    end

    // --------------------------------------------------------------------
    // Status
    // --------------------------------------------------------------------
    // A skipped launch leaves the fault of the last real execution standing.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FAULT <= 1'b0;
        end else if (execute) begin
            FAULT <= next_fault;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ran     <= 1'b0;
            skipped <= 1'b0;
        end else if (launch) begin
            ran     <= EXEC_COND;
            skipped <= !EXEC_COND;
        end
    end

    // --------------------------------------------------------------------
    // Completion pulse
    // --------------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DONE <= 1'b0;
        end else begin
            DONE <= launch;
        end
    end

    // --------------------------------------------------------------------
    // Read port
    // --------------------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        case (ADDR)
            `CV_REG_CMD:    rd_mux = 16'({ptr_use, op});
            `CV_REG_SEL:    rd_mux = sel;
            `CV_REG_ROOM:   rd_mux = room;
            `CV_REG_PTR:    rd_mux = ptr;
            `CV_REG_STATUS: begin
                rd_mux[`CV_ST_FAULT]   = FAULT;
                rd_mux[`CV_ST_RAN]     = ran;
                rd_mux[`CV_ST_SKIPPED] = skipped;
            end
            default: begin
                if (in_bank(ADDR, `CV_REG_SRC0)) begin
                    rd_mux = src[ADDR[1:0]];
                end else if (in_bank(ADDR, `CV_REG_DST0)) begin
                    rd_mux = dst[ADDR[1:0]];
                end
            end
        endcase
    end

    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RD_DATA <= 16'h0000;
        end else if (RD_STB) begin
            RD_DATA <= rd_mux;
        end else begin
            RD_DATA <= 16'h0000;
        end
    end

endmodule

// ==== verif/conv_unit_sva.sv ====
/*
 * Port-level checker for the conversion unit.
 * Assumes it is bound to conv_unit and sees only that module's ports.
 */
`timescale 1ns/1ps

module conv_unit_chk (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        EXEC_COND,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic        WR_STB,
    input wire logic        RD_STB,
    input wire logic [15:0] RD_DATA,
    input wire logic        DONE,
    input wire logic        FAULT
);
    // ----------------------------------------------------------------
    // Shared events
    // ----------------------------------------------------------------
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    wire logic cmd = WR_STB && ADDR == 4'h0;

    sequence s_skip;
        cmd && !EXEC_COND;
    endsequence

    // Guard against a second command landing between skip and read
    sequence s_stat;
        !cmd ##1 RD_STB && ADDR == 4'hC;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    chk_done_follows: assert property (cmd |=> DONE)
        else $error("done missing after command");
    chk_done_alone: assert property (!cmd |=> !DONE)
        else $error("done without command");
    chk_rd_idle: assert property (!RD_STB |=> RD_DATA == 16'h0000)
        else $error("read data not zero when idle");
    chk_fault_steady: assert property (!cmd |=> $stable(FAULT))
        else $error("fault moved without command");
    chk_skip_keeps: assert property (s_skip |=> $stable(FAULT))
        else $error("fault changed on skipped command");
    chk_skip_flag: assert property (s_skip ##1 s_stat |=> RD_DATA[2])
        else $error("skipped flag not set");
    chk_stat_fault: assert property (RD_STB && ADDR == 4'hC |=> RD_DATA[0] == $past(FAULT))
        else $error("status fault bit differs from fault");
    chk_spare_faults: assert property (cmd && EXEC_COND && WR_DATA[1:0] == 2'h3 |=> FAULT)
        else $error("spare operation did not fault");
    chk_unmapped_zero: assert property (RD_STB && ADDR >= 4'hD |=> RD_DATA == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind conv_unit conv_unit_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .EXEC_COND(EXEC_COND), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .DONE(DONE), .FAULT(FAULT));

// ==== verif/digit_decode_encode_ascii_unit_tb.sv ====
/*
 * Self-checking bench for the conversion unit: register tasks and tests.
 * Assumes conv_unit and its register map; the bench drives every port itself.
 */
`timescale 1ns/1ps

module digit_decode_encode_ascii_unit_tb
    import conv_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        cond;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wstb;
    logic        rstb;
    logic [15:0] rdata;
    logic        done;
    logic        fault;
    int          n_mismatch;
    int          checks;

    // Small pointer bound keeps the boundary case cheap to reach
    conv_unit #(.DM_WORDS(20)) dut (.CLK(clk), .ARST_N(arst_n), .EXEC_COND(cond), .ADDR(addr),
        .WR_DATA(wdata), .WR_STB(wstb), .RD_STB(rstb), .RD_DATA(rdata), .DONE(done), .FAULT(fault));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wstb  <= 1'b1;
        @(posedge clk);
        wstb  <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1;
        cmp16(rdata & m, e);
    endtask

    // Command write, then done and fault in the following cycle
    task automatic run(input logic [2:0] c, input logic ec, input logic ef);
        @(posedge clk);
        addr  <= 4'h0;
        wdata <= {13'h0000, c};
        cond  <= ec;
        wstb  <= 1'b1;
        @(posedge clk);
        wstb  <= 1'b0;
        #1;
        cmp1(done, 1'b1);
        cmp1(fault, ef);
    endtask

    function automatic logic [7:0] asc(input logic [3:0] d, input logic [1:0] p);
        logic [7:0] c;
        c = (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
        c[7] = (p == 2'h1) ? ^c[6:0] : (p == 2'h2) ? ~^c[6:0] : 1'b0;
        return c;
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #500000;
        n_mismatch++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] src;
        logic [1:0]  pp;
        {arst_n, cond, addr, wdata, wstb, rstb} = '0;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++) rd(i[3:0], (i == 2) ? 16'h0004 : 16'h0000);
        $display("test reset done");

        src = 16'hC07F;
        wr(4'h4, src);
        for (int i = 8; i < 12; i++) wr(i[3:0], 16'hFFFF);
        wr(4'h1, 16'h0032);
        run(3'h0, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) rd(4'h8 + i[3:0], 16'h0001 << src[4*((2+i)%4)+:4]);
        rd(4'hC, 16'h0002);
        wr(4'h2, 16'h0003);
        wr(4'h8, 16'hAAAA);
        run(3'h0, 1'b1, 1'b1);
        rd(4'h8, 16'hAAAA);
        wr(4'h2, 16'h0004);
        wr(4'h1, 16'h0004);
        run(3'h0, 1'b1, 1'b1);
        wr(4'h1, 16'h0040);
        run(3'h0, 1'b1, 1'b1);
        wr(4'h1, 16'h0000);
        run(3'h0, 1'b0, 1'b1);
        rd(4'hC, 16'h0005, 16'h0005);
        rd(4'h8, 16'hAAAA);
        $display("test decode done");

        wr(4'h4, 16'h0001);
        wr(4'h5, 16'h8000);
        wr(4'h6, 16'h0100);
        wr(4'h7, 16'h0030);
        wr(4'h1, 16'h0033);
        run(3'h1, 1'b1, 1'b0);
        rd(4'h8, 16'h058F);
        wr(4'h4, 16'h0040);
        wr(4'h1, 16'h0001);
        run(3'h1, 1'b1, 1'b0);
        rd(4'h8, 16'h056F);
        wr(4'h6, 16'h0000);
        wr(4'h1, 16'h0020);
        run(3'h1, 1'b1, 1'b1);
        rd(4'h8, 16'h056F);
        wr(4'h6, 16'h0100);
        wr(4'h2, 16'h0002);
        run(3'h1, 1'b1, 1'b1);
        wr(4'h2, 16'h0004);
        run(3'h1, 1'b0, 1'b1);
        rd(4'h8, 16'h056F);
        $display("test encode done");

        wr(4'h4, 16'h9A31);
        for (int p = 0; p < 3; p++) begin
            pp = p[1:0];
            for (int i = 8; i < 12; i++) wr(i[3:0], 16'hEEEE);
            wr(4'h1, {5'h00, pp, 1'b1, 8'h31});
            run(3'h2, 1'b1, 1'b0);
            rd(4'h8, {asc(4'h3, pp), 8'hEE});
            rd(4'h9, {asc(4'h9, pp), asc(4'hA, pp)});
            rd(4'hA, {8'hEE, asc(4'h1, pp)});
            rd(4'hB, 16'hEEEE);
        end
        wr(4'h2, 16'h0002);
        run(3'h2, 1'b1, 1'b1);
        wr(4'h2, 16'h0004);
        wr(4'h1, 16'h0731);
        run(3'h2, 1'b1, 1'b1);
        wr(4'h1, 16'h0831);
        run(3'h2, 1'b1, 1'b1);
        $display("test char code done");

        wr(4'h1, 16'h0000);
        wr(4'h3, 16'h001A);
        run(3'h4, 1'b1, 1'b1);
        wr(4'h3, 16'h0020);
        run(3'h4, 1'b1, 1'b1);
        rd(4'h8, 16'hB3EE);
        wr(4'h3, 16'h0019);
        run(3'h4, 1'b1, 1'b0);
        rd(4'h8, 16'h0002);
        run(3'h3, 1'b1, 1'b1);
        $display("test pointer done");
        conclude();
    end
endmodule
